// File: dv/ext_processor.sv
// external byte-wide processor on the slave interface
// drives the strobe pins and data; reads the resolved data bus
`timescale 1ns/100ps
module ext_processor (
  input  wire       i_clk_sys,
  input  wire [7:0] i_bus,
  output reg  [2:0] o_ctl,
  output reg  [7:0] o_dq
);
  initial begin
    o_ctl = 3'h7;
    o_dq = 8'h5a;
  end
  // strobes held 8 cycles, well above the filter minimum
  task automatic xfer(input rd, input sel, input [7:0] d, output [7:0] q);
    begin
      @(posedge i_clk_sys);
      o_ctl <= {~sel, rd, ~rd};
      o_dq <= d;
      repeat (8) @(posedge i_clk_sys);
      q = i_bus;
      o_ctl <= 3'h7;
      // data kept past the release so the filtered byte is whole
      repeat (6) @(posedge i_clk_sys);
      o_dq <= ~d;
      repeat (4) @(posedge i_clk_sys);
    end
  endtask
endmodule // ext_processor

// File: dv/gpio_psp_monitor.sv
// port assertions for the gpio block with slave interface
// bound to gpio_psp; apb answers with zero wait states
`timescale 1ns/100ps
module gpio_psp_monitor (
  input wire        i_clk_sys,
  input wire        i_reset,
  input wire        i_soft_reset,
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire        o_pslverr,
  input wire [7:0]  o_third_out,
  input wire [7:0]  o_third_oe,
  input wire [7:0]  o_parallel_oe,
  input wire [2:0]  o_control_oe,
  input wire        o_irq
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  reg  [7:0] wd_q;
  wire       wr = i_psel && i_penable && i_pwrite;
  wire       cw = wr && i_paddr == 12'h224 && !i_soft_reset;
  always @(posedge i_clk_sys) begin
    wd_q <= i_pwdata[7:0];
  end
  reset_oe_a: assert property ($past(i_reset) |->
    o_third_oe == 8'h00 && o_control_oe == 3'h0 && o_parallel_oe == 8'h00)
    else $error("drivers on after reset");
  soft_oe_a: assert property (i_soft_reset |=>
    o_third_oe == 8'h00 && o_control_oe == 3'h0)
    else $error("drivers on after soft reset");
  third_dir_a: assert property (wr && i_paddr == 12'h21c &&
    !i_soft_reset |=> o_third_oe == ~wd_q) else $error("third oe wrong");
  third_latch_a: assert property (wr && i_paddr == 12'h01c
    |=> o_third_out == wd_q) else $error("third latch wrong");
  ctl_dir_a: assert property (cw && !i_pwdata[4]
    |=> o_control_oe == ~wd_q[2:0]) else $error("control oe wrong");
  slave_ctl_a: assert property (cw && i_pwdata[4]
    |=> (o_control_oe == 3'h0) [*2]) else $error("control pins driven");
  irq_clear_a: assert property (wr && i_paddr == 12'h034
    && i_pwdata[0] |=> !o_irq) else $error("irq not cleared");
  irq_mask_a: assert property (wr && i_paddr == 12'h230
    && !i_pwdata[0] |=> !o_irq) else $error("irq not masked");
  cover property (o_pslverr);
  cover property ($rose(o_irq));
  cover property ($rose(o_parallel_oe));
endmodule // gpio_psp_monitor

bind gpio_psp gpio_psp_monitor gpio_psp_monitor_i (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_soft_reset(i_soft_reset),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pslverr(o_pslverr),
  .o_third_out(o_third_out), .o_third_oe(o_third_oe),
  .o_parallel_oe(o_parallel_oe), .o_control_oe(o_control_oe),
  .o_irq(o_irq));

// File: dv/testbench.sv
// self-checking bench for gpio_psp with an external processor model
// expects the monitor bound to the design
`timescale 1ns/100ps
module testbench;
  reg        clk = 1'b0, rst = 1'b1, srst = 1'b0;
  reg        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd;
  reg [7:0]  ext3 = 8'h00, d, v, q, r, exp_q[$];
  reg        slv;
  wire [31:0] prdata;
  wire        pready, pslverr, irq;
  wire [7:0]  t_out, t_oe, p_out, p_oe, dq, t_pin, p_pin;
  wire [2:0]  c_out, c_oe, ctl, c_pin;
  integer     n_mismatch = 0, num_checks = 0, seed = 51570, i;
  assign t_pin = (t_oe & t_out) | (~t_oe & ext3);
  assign p_pin = (p_oe & p_out) | (~p_oe & dq);
  assign c_pin = (c_oe & c_out) | (~c_oe & ctl);
  always #2.5 clk = ~clk;
  gpio_psp gpio_psp_i (.i_clk_sys(clk), .i_reset(rst), .i_soft_reset(srst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_third_pin(t_pin), .o_third_out(t_out),
    .o_third_oe(t_oe), .i_parallel_pin(p_pin), .o_parallel_out(p_out),
    .o_parallel_oe(p_oe), .i_control_pin(c_pin), .o_control_out(c_out),
    .o_control_oe(c_oe), .o_irq(irq));
  ext_processor ext_processor_i (.i_clk_sys(clk), .i_bus(p_pin),
    .o_ctl(ctl), .o_dq(dq));
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // entered just after a rising edge; returns one edge after the committing edge
  task apb(input w, input [11:0] a, input [31:0] wd);
    integer k;
    begin
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      do begin
        @(posedge clk);
        k = k + 1;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      // one idle edge so a following call never re-raises psel at once
      @(posedge clk);
      if (k >= 50) begin
        chk(1'b0, 1'b1);
        tally_and_finish;
      end
    end
  endtask
  task wr(input [11:0] a, input [7:0] x);
    apb(1'b1, a, {24'h0, x});
  endtask
  task rdc(input [11:0] a, input [7:0] x);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, {24'h0, x});
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(12'h21c, 8'hff);
    rdc(12'h220, 8'hff);
    rdc(12'h224, 8'h07);
    for (i = 0; i < 4; i = i + 1) begin
      d = $random(seed);
      v = $random(seed);
      ext3 <= $random(seed);
      wr(12'h21c, d);
      wr(12'h01c, v);
      repeat (6) @(posedge clk);
      chk(t_oe, {24'h0, ~d});
      chk(t_out, v);
      r = (~d & v) | (d & ext3);
      rdc(12'h01c, r);
      wr(12'h05c, 8'h81);
      repeat (6) @(posedge clk);
      chk(t_out, r | 8'h81);
      r = (~d & (r | 8'h81)) | (d & ext3);
      wr(12'h09c, 8'h18);
      repeat (6) @(posedge clk);
      chk(t_out, {24'h0, r & ~8'h18});
      wr(12'h224, d & 8'h07);
      wr(12'h024, v);
      repeat (6) @(posedge clk);
      chk(c_oe, {29'h0, ~d[2:0]});
      chk(c_out, {29'h0, v[2:0]});
      rdc(12'h024, (~d[2:0] & v[2:0]) | d[2:0]);
    end
    apb(1'b0, 12'h004, 32'h0);
    chk(slv, 1'b1);
    // control pins become inputs and settle before slave mode is set
    wr(12'h224, 8'h07);
    repeat (6) @(posedge clk);
    wr(12'h224, 8'h17);
    wr(12'h230, 8'h01);
    @(posedge clk);
    chk(c_oe, 3'h0);
    d = $random(seed);
    ext_processor_i.xfer(1'b0, 1'b1, d, q);
    exp_q.push_back(d);
    rdc(12'h224, 8'h97);
    chk(irq, 1'b1);
    ext_processor_i.xfer(1'b0, 1'b1, ~d, q);
    rdc(12'h224, 8'hb7);
    rdc(12'h020, exp_q.pop_front());
    rdc(12'h224, 8'h37);
    wr(12'h034, 8'h01);
    v = $random(seed);
    wr(12'h020, v);
    rdc(12'h224, 8'h77);
    ext_processor_i.xfer(1'b1, 1'b1, 8'h00, q);
    chk(q, v);
    rdc(12'h224, 8'h37);
    chk(irq, 1'b1);
    wr(12'h034, 8'h01);
    ext_processor_i.xfer(1'b0, 1'b0, 8'h3c, q);
    chk(irq, 1'b0);
    rdc(12'h224, 8'h37);
    wr(12'h020, v);
    wr(12'h224, 8'h27);
    rdc(12'h224, 8'h27);
    wr(12'h230, 8'h00);
    wr(12'h01c, 8'h5a);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdc(12'h224, 8'h07);
    chk(t_out, 8'h5a);
    tally_and_finish;
  end
endmodule // testbench

// File: logic/gpio_psp.v
// three gpio ports with a parallel slave interface on the second port
// apb slave, zero wait states; pins are asynchronous to i_clk_sys
`timescale 1ns/100ps
`include "gpio_psp_consts.vh"

// Contract
// - each 8-bit pin direction bit, 1 releases pin
// - 3-bit port pins individually directed by dir[2:0]
// - data register read returns sampled pin levels
// - data register write updates the output latch
// - set and clear writes rewrite whole byte from pin levels
// - slave mode bit makes second port processor port
// - control pins become read, write, select strobes
// - read strobe low while selected drives latch
// - write strobe low while selected captures data
// - select high makes device ignore strobes
// - directions reset to ones, latches kept softly
// - input full and output full flag behaviour
// - overflow on second write, first byte kept
// - full flags held clear outside slave mode
// - transfer completion latches masked interrupt flag
module gpio_psp (
  input  wire        i_clk_sys,
  input  wire        i_reset,
  input  wire        i_soft_reset,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire        o_pready,
  output wire        o_pslverr,
  input  wire [7:0]  i_third_pin,
  output wire [7:0]  o_third_out,
  output wire [7:0]  o_third_oe,
  input  wire [7:0]  i_parallel_pin,
  output wire [7:0]  o_parallel_out,
  output wire [7:0]  o_parallel_oe,
  input  wire [2:0]  i_control_pin,
  output wire [2:0]  o_control_out,
  output wire [2:0]  o_control_oe,
  output wire        o_irq
);
  function hit;
    input [11:0]         addr;
    input [`IDX_W-1:0]   idx;
    begin
      hit = (addr[1:0] == 2'b00) && (addr[11:2] == idx);
    end
  endfunction

  wire [18:0] level;
  wire [7:0]  third_lvl;
  wire [7:0]  parallel_lvl;
  wire [2:0]  control_lvl;

  reg  [7:0]  third_latch_q;
  reg  [7:0]  parallel_latch_q;
  reg  [2:0]  control_latch_q;
  reg  [7:0]  third_dir_q;
  reg  [7:0]  parallel_dir_q;
  reg  [2:0]  control_dir_q;
  reg         slave_mode_q;
  reg         input_full_q;
  reg         output_full_q;
  reg         input_overflow_q;
  reg  [7:0]  slave_in_q;
  reg  [7:0]  capture_q;
  reg         rd_prev_q;
  reg         wr_prev_q;
  reg  [31:0] prdata_q;
  reg  [31:0] rdata_d;

  wire        setup;
  wire        access;
  wire        wr_en;
  wire        rd_en;
  wire        mapped;
  wire        rd_act;
  wire        wr_act;
  wire        rd_done;
  wire        wr_done;
  wire        cpu_rd_parallel;
  wire        cpu_wr_parallel;
  wire        full_eff;
  wire [7:0]  wdata;
  wire [7:0]  ctrl_status;
  wire        irq_status;
  wire        irq_enable;

  // every pin level is seen through four flops before use
  pin_filter #(
    .W (19)
  ) u_filter (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_async   ({i_control_pin, i_parallel_pin, i_third_pin}),
    .o_level   (level)
  );

  assign third_lvl    = level[7:0];
  assign parallel_lvl = level[15:8];
  assign control_lvl  = level[18:16];

  // ---- apb decode
  assign setup  = i_psel & ~i_penable;
  assign access = i_psel & i_penable;
  assign wdata  = i_pwdata[7:0];

  assign mapped = hit(i_paddr, `IDX_THIRD_DATA)
               | hit(i_paddr, `IDX_PARALLEL_DATA)
               | hit(i_paddr, `IDX_CONTROL_DATA)
               | hit(i_paddr, `IDX_THIRD_DIR)
               | hit(i_paddr, `IDX_PARALLEL_DIR)
               | hit(i_paddr, `IDX_CONTROL_DIR)
               | hit(i_paddr, `IDX_THIRD_SET)
               | hit(i_paddr, `IDX_PARALLEL_SET)
               | hit(i_paddr, `IDX_CONTROL_SET)
               | hit(i_paddr, `IDX_THIRD_CLR)
               | hit(i_paddr, `IDX_PARALLEL_CLR)
               | hit(i_paddr, `IDX_CONTROL_CLR)
               | hit(i_paddr, `IDX_IRQ_STATUS)
               | hit(i_paddr, `IDX_IRQ_ENABLE)
               | hit(i_paddr, `IDX_IRQ_CLEAR);

  assign wr_en = access & i_pwrite & mapped;
  assign rd_en = access & ~i_pwrite & mapped;

  assign o_pready  = access;
  assign o_pslverr = access & ~mapped;
  assign o_prdata  = prdata_q;

  assign cpu_rd_parallel = rd_en & hit(i_paddr, `IDX_PARALLEL_DATA);
  assign cpu_wr_parallel = wr_en & (hit(i_paddr, `IDX_PARALLEL_DATA)
                                  | hit(i_paddr, `IDX_PARALLEL_SET)
                                  | hit(i_paddr, `IDX_PARALLEL_CLR));

  // full flags read as clear as soon as slave mode is off, not a cycle later
  assign ctrl_status = {input_full_q & slave_mode_q,
                        output_full_q & slave_mode_q, input_overflow_q,
                        slave_mode_q, 1'b0, control_dir_q};

  // ---- read mux; data are taken in the setup cycle
  always @* begin
    rdata_d = 32'h0000_0000;
    if (hit(i_paddr, `IDX_THIRD_DATA))
      rdata_d[7:0] = third_lvl;
    else if (hit(i_paddr, `IDX_PARALLEL_DATA))
      rdata_d[7:0] = slave_mode_q ? slave_in_q : parallel_lvl;
    else if (hit(i_paddr, `IDX_CONTROL_DATA))
      rdata_d[2:0] = control_lvl;
    else if (hit(i_paddr, `IDX_THIRD_DIR))
      rdata_d[7:0] = third_dir_q;
    else if (hit(i_paddr, `IDX_PARALLEL_DIR))
      rdata_d[7:0] = parallel_dir_q;
    else if (hit(i_paddr, `IDX_CONTROL_DIR))
      rdata_d[7:0] = ctrl_status;
    else if (hit(i_paddr, `IDX_IRQ_STATUS))
      rdata_d[0] = irq_status;
    else if (hit(i_paddr, `IDX_IRQ_ENABLE))
      rdata_d[0] = irq_enable;
  end

  always @(posedge i_clk_sys) begin
    if (i_reset)
      prdata_q <= 32'h0000_0000;
    else if (setup & ~i_pwrite)
      prdata_q <= rdata_d;
  end

  // ---- output latches: hard reset clears, soft reset keeps them
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      third_latch_q    <= `RST_LATCH8;
      parallel_latch_q <= `RST_LATCH8;
      control_latch_q  <= `RST_LATCH3;
    end else if (wr_en) begin
      if (hit(i_paddr, `IDX_THIRD_DATA))
        third_latch_q <= wdata;
      if (hit(i_paddr, `IDX_THIRD_SET))
        third_latch_q <= third_lvl | wdata;
      if (hit(i_paddr, `IDX_THIRD_CLR))
        third_latch_q <= third_lvl & ~wdata;
      if (hit(i_paddr, `IDX_PARALLEL_DATA))
        parallel_latch_q <= wdata;
      if (hit(i_paddr, `IDX_PARALLEL_SET))
        parallel_latch_q <= parallel_lvl | wdata;
      if (hit(i_paddr, `IDX_PARALLEL_CLR))
        parallel_latch_q <= parallel_lvl & ~wdata;
      if (hit(i_paddr, `IDX_CONTROL_DATA))
        control_latch_q <= wdata[2:0];
      if (hit(i_paddr, `IDX_CONTROL_SET))
        control_latch_q <= control_lvl | wdata[2:0];
      if (hit(i_paddr, `IDX_CONTROL_CLR))
        control_latch_q <= control_lvl & ~wdata[2:0];
    end
  end

  // ---- direction registers and slave mode select
  always @(posedge i_clk_sys) begin
    if (i_reset | i_soft_reset) begin
      third_dir_q    <= `RST_DIR8;
      parallel_dir_q <= `RST_DIR8;
      control_dir_q  <= `RST_DIR3;
      slave_mode_q   <= 1'b0;
    end else if (wr_en) begin
      if (hit(i_paddr, `IDX_THIRD_DIR))
        third_dir_q <= wdata;
      if (hit(i_paddr, `IDX_PARALLEL_DIR))
        parallel_dir_q <= wdata;
      if (hit(i_paddr, `IDX_CONTROL_DIR)) begin
        control_dir_q <= wdata[2:0];
        slave_mode_q  <= wdata[`BIT_SLAVE_MODE];
      end
    end
  end

  // ---- slave strobes, from filtered levels only
  // select high masks both strobes
  assign rd_act = slave_mode_q & ~control_lvl[`PIN_SELECT]
                & ~control_lvl[`PIN_READ_STROBE];
  assign wr_act = slave_mode_q & ~control_lvl[`PIN_SELECT]
                & ~control_lvl[`PIN_WRITE_STROBE];
  assign rd_done = rd_prev_q & ~rd_act;
  assign wr_done = wr_prev_q & ~wr_act;

  // a cpu read in the same cycle frees the buffer for the new byte
  assign full_eff = input_full_q & ~cpu_rd_parallel;

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
      capture_q <= 8'h00;
    end else begin
      rd_prev_q <= rd_act;
      wr_prev_q <= wr_act;
      if (wr_act)
        capture_q <= parallel_lvl;
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      slave_in_q       <= `RST_LATCH8;
      input_full_q     <= 1'b0;
      output_full_q    <= 1'b0;
      input_overflow_q <= 1'b0;
    end else begin
      if (!slave_mode_q) begin
        input_full_q  <= 1'b0;
        output_full_q <= 1'b0;
      end else begin
        if (wr_done & ~full_eff) begin
          slave_in_q   <= capture_q;
          input_full_q <= 1'b1;
        end else if (cpu_rd_parallel)
          input_full_q <= 1'b0;
        if (cpu_wr_parallel)
          output_full_q <= 1'b1;
        else if (rd_done)
          output_full_q <= 1'b0;
      end
      // overflow survives mode changes; set beats a software clear
      if (wr_done & full_eff)
        input_overflow_q <= 1'b1;
      else if (i_soft_reset)
        input_overflow_q <= 1'b0;
      else if (wr_en & hit(i_paddr, `IDX_CONTROL_DIR))
        input_overflow_q <= wdata[`BIT_INPUT_OVERFLOW];
    end
  end

  irq_flags #(
    .W (1)
  ) u_irq (
    .i_clk_sys  (i_clk_sys),
    .i_reset    (i_reset),
    .i_event    (rd_done | wr_done),
    .i_clr_we   (wr_en & hit(i_paddr, `IDX_IRQ_CLEAR)),
    .i_clr_bits (i_pwdata[0]),
    .i_en_we    (wr_en & hit(i_paddr, `IDX_IRQ_ENABLE)),
    .i_en_bits  (i_pwdata[0]),
    .o_status   (irq_status),
    .o_enable   (irq_enable),
    .o_irq      (o_irq)
  );

  // ---- pin drivers; enable high means the pin is driven
  assign o_third_out    = third_latch_q;
  assign o_third_oe     = ~third_dir_q;
  assign o_parallel_out = parallel_latch_q;
  // in slave mode the direction register is ignored
  assign o_parallel_oe  = slave_mode_q ? {8{rd_act}}
                                       : ~parallel_dir_q;
  assign o_control_out  = control_latch_q;
  // never drive the strobe pins in slave mode, even if misprogrammed
  assign o_control_oe   = slave_mode_q ? 3'b000
                                       : ~control_dir_q;
endmodule // gpio_psp

// File: logic/gpio_psp_consts.vh
// register indices, field positions and reset values of the gpio block
// included by the gpio top level; holds definitions only
`ifndef GPIO_PSP_CONSTS_VH
`define GPIO_PSP_CONSTS_VH

// register indices; byte address on apb is four times the index
`define IDX_W                  10
`define IDX_THIRD_DATA         10'h007
`define IDX_PARALLEL_DATA      10'h008
`define IDX_CONTROL_DATA       10'h009
`define IDX_THIRD_DIR          10'h087
`define IDX_PARALLEL_DIR       10'h088
`define IDX_CONTROL_DIR        10'h089
`define IDX_THIRD_SET          10'h017
`define IDX_PARALLEL_SET       10'h018
`define IDX_CONTROL_SET        10'h019
`define IDX_THIRD_CLR          10'h027
`define IDX_PARALLEL_CLR       10'h028
`define IDX_CONTROL_CLR        10'h029
`define IDX_IRQ_STATUS         10'h00c
`define IDX_IRQ_ENABLE         10'h08c
`define IDX_IRQ_CLEAR          10'h00d

// fields of control_direction_and_slave_status
`define BIT_INPUT_FULL         7
`define BIT_OUTPUT_FULL        6
`define BIT_INPUT_OVERFLOW     5
`define BIT_SLAVE_MODE         4

// control pin positions in slave mode
`define PIN_READ_STROBE        0
`define PIN_WRITE_STROBE       1
`define PIN_SELECT             2

// reset values
`define RST_DIR8               8'hff
`define RST_DIR3               3'h7
`define RST_LATCH8             8'h00
`define RST_LATCH3             3'h0

`endif

// File: logic/irq_flags.v
// sticky interrupt status with write-one-to-clear and enable mask
// events are single-cycle pulses in the system clock domain
`timescale 1ns/100ps
module irq_flags #(
  parameter W = 1
) (
  input  wire         i_clk_sys,
  input  wire         i_reset,
  input  wire [W-1:0] i_event,
  input  wire         i_clr_we,
  input  wire [W-1:0] i_clr_bits,
  input  wire         i_en_we,
  input  wire [W-1:0] i_en_bits,
  output wire [W-1:0] o_status,
  output wire [W-1:0] o_enable,
  output wire         o_irq
);
  reg [W-1:0] status_q;
  reg [W-1:0] enable_q;
  wire [W-1:0] clr_mask;

  assign clr_mask = i_clr_we ? i_clr_bits : {W{1'b0}};

  // a new event beats a clear in the same cycle
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      status_q <= {W{1'b0}};
      enable_q <= {W{1'b0}};
    end else begin
      status_q <= (status_q & ~clr_mask) | i_event;
      if (i_en_we)
        enable_q <= i_en_bits;
    end
  end

  assign o_status = status_q;
  assign o_enable = enable_q;
  assign o_irq    = |(status_q & enable_q);
endmodule // irq_flags

// File: logic/pin_filter.v
// three-stage synchroniser for asynchronous pin inputs
// a new level is taken once the second and third stages agree
`timescale 1ns/100ps
module pin_filter #(
  parameter W = 19
) (
  input  wire         i_clk_sys,
  input  wire         i_reset,
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_level
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] level_q;
  genvar g;

  // idle level high: strobes and select are inactive high
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      s1_q <= {W{1'b1}};
      s2_q <= {W{1'b1}};
      s3_q <= {W{1'b1}};
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge i_clk_sys) begin
        if (i_reset)
          level_q[g] <= 1'b1;
        else if (s2_q[g] == s3_q[g])
          level_q[g] <= s3_q[g];
      end
    end
  endgenerate

  assign o_level = level_q;
endmodule // pin_filter
